// File: src/rtc_timekeeping_core.sv
`timescale 1ns/10ps
module rtc_timekeeping_core
	import rtc_pkg::*;
(
	input wire logic sys_clk, // system clock, 250 MHz
	input wire logic rst, // power-on reset, synchronous, high
	input wire logic warm_rst, // watchdog or pin reset, high
	input wire logic crystal_tick, // one-cycle pulse per crystal edge
	input wire rtc_pkg::sfr_req_t sfr_req, // byte-wide register access
	output logic [7:0] sfr_rdata, // read data, registered
	output logic [7:0] pin_interrupt_config, // guarded pin config
	output logic interval_base_tick, // one pulse per 1/128 s, base code 00 only
	output logic deep_save_allowed // low while day-wrap pending
);
	import rtc_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [7:0] unlock_key_q; // key register
	logic [7:0] centi_q; // hundredths
	logic [7:0] sec_q; // seconds
	logic [7:0] min_q; // minutes
	logic [7:0] hour_q; // hours
	logic day_wrap_q; // midnight flag
	logic day_format_select_q; // 1 = 24 hour
	logic [1:0] interval_base_select_q; // time base code
	logic [7:0] alarm_interval_count_q; // interval setting
	logic [7:0] nominal_trim_q; // signed trim, crystal error
	logic [7:0] thermal_trim_q; // signed trim, temperature drift
	logic [7:0] pin_cfg_q; // guarded pin config
	logic [15:0] frac_acc_q; // fractional hundredth accumulator
	logic [15:0] base_div_q; // base tick divider
	logic interval_tick_q; // base tick output
	logic [7:0] rdata_q; // read data

	// ----------------------------------------
	// decode
	// ----------------------------------------
	logic unlocked; // key present
	logic wr_cfg, wr_centi, wr_sec, wr_min, wr_hour, wr_pin;
	logic centi_step; // hundredth elapsed
	logic sec_carry, min_carry, hour_carry, day_roll;
	logic [7:0] hour_last; // wrap point for current format
	logic signed [16:0] step_x100; // trimmed step size

	// whole-byte writes only, no bit addressing
	assign unlocked = (unlock_key_q == KEY_TIMEKEEPING);
	assign wr_cfg = sfr_req.wr && sfr_req.addr == ADDR_RTC_CONFIG;
	assign wr_centi = sfr_req.wr && sfr_req.addr == ADDR_CENTI && unlocked;
	assign wr_sec = sfr_req.wr && sfr_req.addr == ADDR_ONE_HZ && unlocked;
	assign wr_min = sfr_req.wr && sfr_req.addr == ADDR_HOUR_FRAC && unlocked;
	assign wr_hour = sfr_req.wr && sfr_req.addr == ADDR_HOUR && unlocked;
	assign wr_pin = sfr_req.wr && sfr_req.addr == ADDR_PIN_INT_CONFIG && unlocked;

	// trims add signed fine steps; each count is 1/100 of a crystal cycle
	assign step_x100 = 17'(CENTI_STEP_X100) + 17'($signed(nominal_trim_q)) + 17'($signed(thermal_trim_q));

	// ----------------------------------------
	// hundredth generator from the crystal
	// ----------------------------------------
	// crystal ticks add 100 per tick; a hundredth passes at the trimmed step
	// note: free of power mode inputs, so counting never stops
	assign centi_step = crystal_tick && ({1'b0, frac_acc_q} + 17'd100 >= step_x100);

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			frac_acc_q <= 16'h0000;
		else if (crystal_tick)
		begin
			if (centi_step)
				frac_acc_q <= 16'({1'b0, frac_acc_q} + 17'd100 - step_x100);
			else
				frac_acc_q <= frac_acc_q + 16'd100;
		end
	end

	// ----------------------------------------
	// carry chain
	// ----------------------------------------
	assign hour_last = day_format_select_q ? HOUR_LAST_24 : HOUR_LAST_256;
	assign sec_carry = centi_step && centi_q == CENTI_LAST;
	assign min_carry = sec_carry && sec_q == SIXTY_LAST;
	assign hour_carry = min_carry && min_q == SIXTY_LAST;
	assign day_roll = hour_carry && hour_q == hour_last;

	// counters: only power-on clears, warm reset leaves them alone
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			centi_q <= RESET_BYTE;
			sec_q <= RESET_BYTE;
			min_q <= RESET_BYTE;
			hour_q <= RESET_BYTE;
		end
		else
		begin
			// hundredths
			if (wr_centi)
				centi_q <= sfr_req.wdata;
			else if (sec_carry)
				centi_q <= RESET_BYTE;
			else if (centi_step)
				centi_q <= centi_q + 8'd1;
			// seconds
			if (wr_sec)
				sec_q <= sfr_req.wdata;
			else if (min_carry)
				sec_q <= RESET_BYTE;
			else if (sec_carry)
				sec_q <= sec_q + 8'd1;
			// minutes
			if (wr_min)
				min_q <= sfr_req.wdata;
			else if (hour_carry)
				min_q <= RESET_BYTE;
			else if (min_carry)
				min_q <= min_q + 8'd1;
			// hours, wrap point by format
			if (wr_hour)
				hour_q <= sfr_req.wdata;
			else if (day_roll)
				hour_q <= RESET_BYTE;
			else if (hour_carry)
				hour_q <= hour_q + 8'd1;
		end
	end

	// ----------------------------------------
	// configuration and day-wrap flag
	// ----------------------------------------
	// set wins over a clearing write in the same cycle; software cannot set it
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			day_wrap_q <= 1'b0;
		else if (day_roll)
			day_wrap_q <= 1'b1;
		else if (wr_cfg && !sfr_req.wdata[DAY_WRAP_BIT])
			day_wrap_q <= 1'b0;
	end

	// format bit held over warm reset
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			day_format_select_q <= 1'b0;
		else if (wr_cfg)
			day_format_select_q <= sfr_req.wdata[DAY_FORMAT_BIT];
	end

	// base select and the alarm interval setting follow warm reset too
	always_ff @(posedge sys_clk)
	begin
		if (rst || warm_rst)
		begin
			interval_base_select_q <= 2'b00;
			alarm_interval_count_q <= RESET_BYTE;
		end
		else
		begin
			if (wr_cfg)
				interval_base_select_q <= sfr_req.wdata[BASE_SEL_HI:BASE_SEL_LO];
			if (sfr_req.wr && sfr_req.addr == ADDR_ALARM_INTERVAL)
				alarm_interval_count_q <= sfr_req.wdata;
		end
	end

	// trims kept across warm reset so calibration holds
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			nominal_trim_q <= RESET_BYTE;
			thermal_trim_q <= RESET_BYTE;
		end
		else if (sfr_req.wr)
		begin
			if (sfr_req.addr == ADDR_NOMINAL_TRIM)
				nominal_trim_q <= sfr_req.wdata;
			if (sfr_req.addr == ADDR_THERMAL_TRIM)
				thermal_trim_q <= sfr_req.wdata;
		end
	end

	// key register and guarded pin config
	always_ff @(posedge sys_clk)
	begin
		if (rst || warm_rst)
		begin
			unlock_key_q <= RESET_BYTE;
			pin_cfg_q <= RESET_BYTE;
		end
		else
		begin
			if (sfr_req.wr && sfr_req.addr == ADDR_UNLOCK_KEY)
				unlock_key_q <= sfr_req.wdata;
			if (wr_pin)
				pin_cfg_q <= sfr_req.wdata;
		end
	end

	// ----------------------------------------
	// interval time base
	// ----------------------------------------
	// only code 00 (1/128 s) produces ticks; other bases live in the timer
	always_ff @(posedge sys_clk)
	begin
		if (rst || interval_base_select_q != 2'b00)
		begin
			base_div_q <= 16'h0000;
			interval_tick_q <= 1'b0;
		end
		else
		begin
			interval_tick_q <= 1'b0;
			if (crystal_tick)
			begin
				if (base_div_q == 16'(BASE_128_DIV - 1))
				begin
					base_div_q <= 16'h0000;
					interval_tick_q <= 1'b1;
				end
				else
					base_div_q <= base_div_q + 16'd1;
			end
		end
	end

	// ----------------------------------------
	// read path
	// ----------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			rdata_q <= RESET_BYTE;
		else if (sfr_req.rd)
		begin
			case (sfr_req.addr)
				ADDR_RTC_CONFIG: rdata_q <= {day_wrap_q, day_format_select_q, interval_base_select_q, 4'h0};
				ADDR_CENTI: rdata_q <= centi_q;
				ADDR_ONE_HZ: rdata_q <= sec_q;
				ADDR_HOUR_FRAC: rdata_q <= min_q;
				ADDR_HOUR: rdata_q <= hour_q;
				ADDR_ALARM_INTERVAL: rdata_q <= alarm_interval_count_q;
				ADDR_NOMINAL_TRIM: rdata_q <= nominal_trim_q;
				ADDR_THERMAL_TRIM: rdata_q <= thermal_trim_q;
				ADDR_UNLOCK_KEY: rdata_q <= unlock_key_q;
				ADDR_PIN_INT_CONFIG: rdata_q <= pin_cfg_q;
				default: rdata_q <= RESET_BYTE;
			endcase
		end
	end

	assign sfr_rdata = rdata_q;
	assign pin_interrupt_config = pin_cfg_q;
	assign interval_base_tick = interval_tick_q;
	assign deep_save_allowed = !day_wrap_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_locked_hour_write: assert property (@(posedge sys_clk) disable iff (rst)
		(sfr_req.wr && sfr_req.addr == ADDR_HOUR && !unlocked && !hour_carry) |=> hour_q == $past(hour_q))
		else $error("hour changed without key");
	a_pin_cfg_guard: assert property (@(posedge sys_clk) disable iff (rst || warm_rst)
		(sfr_req.wr && sfr_req.addr == ADDR_PIN_INT_CONFIG && unlocked) |=> pin_interrupt_config == $past(sfr_req.wdata))
		else $error("pin config not written with key");
	a_day_wrap_set: assert property (@(posedge sys_clk) disable iff (rst)
		day_roll |=> day_wrap_q && hour_q == 8'h00 && min_q == 8'h00 && sec_q == 8'h00 && centi_q == 8'h00)
		else $error("rollover did not flag");
	a_day_wrap_clear: assert property (@(posedge sys_clk) disable iff (rst)
		(wr_cfg && !sfr_req.wdata[DAY_WRAP_BIT] && !day_roll) |=> !day_wrap_q)
		else $error("flag clear ignored");
	a_flag_hold_clear: assert property (@(posedge sys_clk) disable iff (rst)
		(!day_wrap_q && !day_roll) |=> !day_wrap_q)
		else $error("flag rose without rollover");
	a_hour_24_wrap: assert property (@(posedge sys_clk) disable iff (rst)
		(day_format_select_q && hour_carry && hour_q == 8'h17 && !wr_hour) |=> hour_q == 8'h00)
		else $error("24-hour wrap wrong");
	a_hour_256_wrap: assert property (@(posedge sys_clk) disable iff (rst)
		(!day_format_select_q && hour_carry && hour_q == 8'h17 && !wr_hour) |=> hour_q == 8'h18)
		else $error("256-hour wrap wrong");
	a_warm_keep_time: assert property (@(posedge sys_clk) disable iff (rst)
		(warm_rst && !sfr_req.wr && !centi_step) |=> centi_q == $past(centi_q)
		&& day_format_select_q == $past(day_format_select_q))
		else $error("warm reset disturbed time");
	// once blocked, only a clearing config write may let the deep state back in
	a_deep_block: assert property (@(posedge sys_clk) disable iff (rst)
		(!deep_save_allowed && !(wr_cfg && !sfr_req.wdata[DAY_WRAP_BIT])) |=> !deep_save_allowed)
		else $error("deep state allowed with flag");
	a_sec_carry_chain: assert property (@(posedge sys_clk) disable iff (rst)
		(sec_carry && !wr_sec && !min_carry && !wr_centi) |=> sec_q == $past(sec_q) + 8'd1 && centi_q == 8'h00)
		else $error("seconds carry lost");

endmodule

// File: src/rtc_pkg.sv
package rtc_pkg;

	// ----------------------------------------
	// register addresses (byte-wide special function space)
	// ----------------------------------------
	localparam logic [7:0] ADDR_RTC_CONFIG = 8'h00_A1;
	localparam logic [7:0] ADDR_CENTI = 8'h00_A2;
	localparam logic [7:0] ADDR_ONE_HZ = 8'h00_A3;
	localparam logic [7:0] ADDR_HOUR_FRAC = 8'h00_A4;
	localparam logic [7:0] ADDR_HOUR = 8'h00_A5;
	localparam logic [7:0] ADDR_ALARM_INTERVAL = 8'h00_A6;
	localparam logic [7:0] ADDR_NOMINAL_TRIM = 8'h00_F6;
	localparam logic [7:0] ADDR_THERMAL_TRIM = 8'h00_F7;
	localparam logic [7:0] ADDR_UNLOCK_KEY = 8'h00_C1;
	localparam logic [7:0] ADDR_PIN_INT_CONFIG = 8'h00_FF;

	// ----------------------------------------
	// key value and field positions
	// ----------------------------------------
	localparam logic [7:0] KEY_TIMEKEEPING = 8'h00_EA;
	localparam int DAY_WRAP_BIT = 7;
	localparam int DAY_FORMAT_BIT = 6;
	localparam int BASE_SEL_LO = 4;
	localparam int BASE_SEL_HI = 5;

	// ----------------------------------------
	// reset values and wrap limits
	// ----------------------------------------
	localparam logic [7:0] RESET_BYTE = 8'h00_00;
	localparam logic [7:0] CENTI_LAST = 8'h00_63;
	localparam logic [7:0] SIXTY_LAST = 8'h00_3B;
	localparam logic [7:0] HOUR_LAST_24 = 8'h00_17;
	localparam logic [7:0] HOUR_LAST_256 = 8'h00_FF;

	// ----------------------------------------
	// crystal tick arithmetic
	// ----------------------------------------
	localparam int CRYSTAL_HZ = 32768;
	localparam int CENTI_PER_SEC = 100;
	localparam int BASE_128_PER_SEC = 128;
	// crystal cycles per hundredth, in 1/100 units (327.68)
	localparam int CENTI_STEP_X100 = CRYSTAL_HZ;
	localparam int CENTI_WRAP_X100 = CENTI_PER_SEC * CENTI_PER_SEC;
	localparam int BASE_128_DIV = CRYSTAL_HZ / BASE_128_PER_SEC;

	// ----------------------------------------
	// register bus request, one byte access
	// ----------------------------------------
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sfr_req_t;

endpackage

// File: bench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
	import rtc_pkg::*;

	// ----------------------------------------
	// stimulus and observed signals
	// ----------------------------------------
	logic sys_clk = 1'b0; // 250 MHz system clock
	logic rst = 1'b1; // power-on reset
	logic warm_rst = 1'b0; // watchdog or pin reset
	logic crystal_tick = 1'b0; // crystal period pulse
	sfr_req_t req = '0; // register access request
	logic [7:0] sfr_rdata; // read data
	logic [7:0] pin_interrupt_config; // guarded pin config
	logic interval_base_tick; // time base pulse
	logic deep_save_allowed; // deep state permission
	int mismatches = 0; // failed comparisons
	int n_tests = 0; // comparisons made
	int n_base = 0; // time base pulses seen
	int base_start = 0; // pulse count when the base test starts
	// every mapped register except pin config, read once after power-on
	logic [7:0] reset_addrs [9] = '{ADDR_RTC_CONFIG, ADDR_CENTI, ADDR_ONE_HZ, ADDR_HOUR_FRAC, ADDR_HOUR,
		ADDR_ALARM_INTERVAL, ADDR_NOMINAL_TRIM, ADDR_THERMAL_TRIM, ADDR_UNLOCK_KEY};
	logic [7:0] v; // scratch read value

	rtc_timekeeping_core DUT (
		.sys_clk(sys_clk),
		.rst(rst),
		.warm_rst(warm_rst),
		.crystal_tick(crystal_tick),
		.sfr_req(req),
		.sfr_rdata(sfr_rdata),
		.pin_interrupt_config(pin_interrupt_config),
		.interval_base_tick(interval_base_tick),
		.deep_save_allowed(deep_save_allowed)
	);

	// clock: invert every half period
	always #2 sys_clk = ~sys_clk;

	// count base pulses; sampled on the edge the design updates
	always @(posedge sys_clk)
		if (interval_base_tick === 1'b1)
			n_base <= n_base + 1;

	// ----------------------------------------
	// compare and report tasks
	// ----------------------------------------
	task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
	begin
		n_tests++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	end
	endtask

	task automatic chk1(input string name, input logic exp, input logic got);
	begin
		n_tests++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value %s expected %b seen %b", name, exp, got);
		end
	end
	endtask

	task automatic final_report;
	begin
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	end
	endtask

	// ----------------------------------------
	// access tasks: one-cycle strobes set at the falling edge
	// ----------------------------------------
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
	begin
		@(negedge sys_clk);
		req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge sys_clk);
		req = '0;
	end
	endtask

	// extra cycle before sampling; read data holds until the next read
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
	begin
		@(negedge sys_clk);
		req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00_00};
		@(negedge sys_clk);
		req = '0;
		@(negedge sys_clk);
		d = sfr_rdata;
	end
	endtask

	task automatic tick;
	begin
		@(negedge sys_clk);
		crystal_tick = 1'b1;
		@(negedge sys_clk);
		crystal_tick = 1'b0;
	end
	endtask

	// preset one hundredth before a wrap, run until hundredths roll, check all
	task automatic roll(input logic fmt, input logic [7:0] hr, input logic [7:0] exp_hr, input logic flag);
	begin
		wr_reg(ADDR_RTC_CONFIG, {1'b0, fmt, 6'b00_0000});
		wr_reg(ADDR_UNLOCK_KEY, KEY_TIMEKEEPING);
		wr_reg(ADDR_HOUR, hr);
		wr_reg(ADDR_HOUR_FRAC, SIXTY_LAST);
		wr_reg(ADDR_ONE_HZ, SIXTY_LAST);
		wr_reg(ADDR_CENTI, CENTI_LAST);
		wr_reg(ADDR_UNLOCK_KEY, 8'h00_00);
		v = CENTI_LAST;
		// one hundredth is about 328 crystal ticks; 400 bounds the wait
		for (int i = 0; i < 400 && v === CENTI_LAST; i++)
		begin
			tick();
			rd_reg(ADDR_CENTI, v);
		end
		chk8("centi", 8'h00_00, v);
		rd_reg(ADDR_ONE_HZ, v);
		chk8("seconds", 8'h00_00, v);
		rd_reg(ADDR_HOUR_FRAC, v);
		chk8("minutes", 8'h00_00, v);
		rd_reg(ADDR_HOUR, v);
		chk8("hours", exp_hr, v);
		rd_reg(ADDR_RTC_CONFIG, v);
		chk8("config after wrap", {flag, fmt, 6'b00_0000}, v);
		chk1("deep save", ~flag, deep_save_allowed);
		// writing bit 7 as zero acknowledges the event
		wr_reg(ADDR_RTC_CONFIG, {1'b0, fmt, 6'b00_0000});
		rd_reg(ADDR_RTC_CONFIG, v);
		chk8("config cleared", {1'b0, fmt, 6'b00_0000}, v);
		chk1("deep save cleared", 1'b1, deep_save_allowed);
	end
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		repeat (6) @(negedge sys_clk);
		rst = 1'b0;
		// every mapped register except pin config starts at zero after power-on
		for (int i = 0; i < 9; i++)
		begin
			rd_reg(reset_addrs[i], v);
			chk8("reset value", RESET_BYTE, v);
		end
		rd_reg(ADDR_RTC_CONFIG, v);
		chk8("config reset", RESET_BYTE, v);
		rd_reg(ADDR_HOUR, v);
		chk8("hour reset", RESET_BYTE, v);
		chk1("deep save reset", 1'b1, deep_save_allowed);
		// guarded writes without the key are dropped
		wr_reg(ADDR_HOUR, 8'h00_05);
		wr_reg(ADDR_PIN_INT_CONFIG, 8'h00_80);
		rd_reg(ADDR_HOUR, v);
		chk8("hour locked", 8'h00_00, v);
		chk8("pin cfg locked", 8'h00_00, pin_interrupt_config);
		// with the key loaded the same writes land
		wr_reg(ADDR_UNLOCK_KEY, KEY_TIMEKEEPING);
		wr_reg(ADDR_PIN_INT_CONFIG, 8'h00_80);
		wr_reg(ADDR_HOUR, 8'h00_05);
		wr_reg(ADDR_UNLOCK_KEY, 8'h00_00);
		wr_reg(ADDR_HOUR, 8'h00_07);
		rd_reg(ADDR_HOUR, v);
		chk8("hour unlocked", 8'h00_05, v);
		chk8("pin cfg unlocked", 8'h00_80, pin_interrupt_config);
		// plain read/write places, then an unmapped address
		for (int i = 0; i < 3; i++)
		begin
			logic [7:0] a;
			a = (i == 0) ? ADDR_ALARM_INTERVAL : (i == 1) ? ADDR_NOMINAL_TRIM : ADDR_THERMAL_TRIM;
			wr_reg(a, 8'h00_5A);
			rd_reg(a, v);
			chk8("plain register", 8'h00_5A, v);
			wr_reg(a, 8'h00_00);
		end
		wr_reg(8'h00_10, 8'h00_33);
		rd_reg(8'h00_10, v);
		chk8("unmapped", 8'h00_00, v);
		// warm reset keeps time and format, drops key and pin config
		wr_reg(ADDR_RTC_CONFIG, 8'h00_40);
		wr_reg(ADDR_UNLOCK_KEY, KEY_TIMEKEEPING);
		@(negedge sys_clk);
		warm_rst = 1'b1;
		repeat (2) @(negedge sys_clk);
		warm_rst = 1'b0;
		rd_reg(ADDR_HOUR, v);
		chk8("hour after warm", 8'h00_05, v);
		rd_reg(ADDR_RTC_CONFIG, v);
		chk8("config after warm", 8'h00_40, v);
		rd_reg(ADDR_UNLOCK_KEY, v);
		chk8("key after warm", 8'h00_00, v);
		chk8("pin cfg after warm", 8'h00_00, pin_interrupt_config);
		// wraps: 24-hour midnight, 256-hour past 23, 256-hour from 255
		roll(1'b1, HOUR_LAST_24, 8'h00_00, 1'b1);
		roll(1'b0, HOUR_LAST_24, 8'h00_18, 1'b0);
		roll(1'b0, HOUR_LAST_256, 8'h00_00, 1'b1);
		// base code 00: one pulse per 256 crystal ticks
		repeat (2) @(negedge sys_clk);
		base_start = n_base;
		repeat (1024) tick();
		repeat (2) @(negedge sys_clk);
		chk8("base pulses", 8'h00_04, 8'(n_base - base_start));
		final_report();
	end

	// watchdog: the whole sequence needs well under 30000 cycles
	initial
	begin
		repeat (60000) @(posedge sys_clk);
		mismatches++;
		final_report();
	end
endmodule
